//--- rtcct_consts.svh
`ifndef RTCCT_CONSTS_SVH
`define RTCCT_CONSTS_SVH
`define RTCCT_IDX_SECMIN   10'h010
`define RTCCT_IDX_HRDAY    10'h011
`define RTCCT_IDX_DATEMON  10'h012
`define RTCCT_IDX_YEAR     10'h013
`define RTCCT_IDX_CTRL     10'h017
`define RTCCT_MIN_MSB      14
`define RTCCT_MIN_LSB      8
`define RTCCT_SEC_MSB      6
`define RTCCT_SEC_LSB      0
`define RTCCT_WDAY_MSB     10
`define RTCCT_WDAY_LSB     8
`define RTCCT_PM_BIT       5
`define RTCCT_HR_MSB       4
`define RTCCT_HR24_MSB     5
`define RTCCT_HR_LSB       0
`define RTCCT_MON_MSB      12
`define RTCCT_MON_LSB      8
`define RTCCT_DATE_MSB     5
`define RTCCT_DATE_LSB     0
`define RTCCT_CENT_MSB     13
`define RTCCT_CENT_LSB     8
`define RTCCT_YR_MSB       7
`define RTCCT_YR_LSB       0
`define RTCCT_BCD_BIT      15
`define RTCCT_12H_BIT      14
`define RTCCT_HALT_BIT     11
`define RTCCT_STS_BIT      10
`define RTCCT_RST_MIN      7'h00
`define RTCCT_RST_SEC      7'h00
`define RTCCT_RST_WDAY     3'h1
`define RTCCT_RST_HOUR     5'h00
`define RTCCT_RST_MONTH    5'h01
`define RTCCT_RST_DATE     6'h01
`define RTCCT_RST_YEAR     8'h00
`define RTCCT_CENTURY      8'h14
`define RTCCT_SEC_MAX      7'h3B
`define RTCCT_HR_MAX       5'h17
`define RTCCT_HR_NOON      5'h0C
`define RTCCT_WDAY_MAX     3'h7
`define RTCCT_MON_MAX      5'h0C
`define RTCCT_DATE_MAX     6'h1F
`define RTCCT_YR_MAX       8'h63
`define RTCCT_TICK_S       1
`define RTCCT_CLK_HZ       200000000
`define RTCCT_TICK_CYCLES  (`RTCCT_TICK_S * `RTCCT_CLK_HZ)
`endif

//--- rtcct_pkg.sv
package rtcct_pkg;
   typedef struct packed {
      logic [7:0] year;
      logic [4:0] month;
      logic [5:0] date;
      logic [2:0] wday;
      logic [4:0] hour;
      logic [6:0] min;
      logic [6:0] sec;
   } rtcct_time_s;

   typedef enum logic [2:0] {
      RTCCT_SEL_NONE    = 3'b000,
      RTCCT_SEL_SECMIN  = 3'b001,
      RTCCT_SEL_HRDAY   = 3'b010,
      RTCCT_SEL_DATEMON = 3'b011,
      RTCCT_SEL_YEAR    = 3'b100,
      RTCCT_SEL_CTRL    = 3'b101
   } rtcct_sel_e;

   function automatic logic [7:0] rtcct_to_bcd(input logic [7:0] v);
      logic [7:0] tens;
      logic [7:0] units;
      tens = v / 8'h0A;
      units = v - 8'(tens * 8'h0A);
      return {tens[3:0], units[3:0]};
   endfunction

   function automatic logic [7:0] rtcct_from_bcd(input logic [7:0] v);
      return 8'({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
   endfunction
endpackage

//--- rtcct_time_regs.sv
`timescale 1ns/1ps
`include "rtcct_consts.svh"
module rtcct_time_regs
   import rtcct_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `RTCCT_TICK_CYCLES,
   parameter int unsigned ADDR_W      = 12
)(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr
);

   generate
      if (TICK_CYCLES < 2 || ADDR_W < 12 || ADDR_W > 32) begin : g_bad
         $error("rtcct_time_regs: unsupported parameter values");
      end
   endgenerate

   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   rtcct_time_s t_r;
   rtcct_time_s t_nxt;
   logic        bcd_r;
   logic        twelve_r;
   logic        halt_r;
   logic [31:0] pre_r;
   logic [31:0] prdata_r;
   logic        pslverr_r;
   logic        tick;
   logic        wr;
   logic        setup;
   rtcct_sel_e  sel;
   logic [15:0] v_secmin;
   logic [15:0] v_hrday;
   logic [15:0] v_datemon;
   logic [15:0] v_year;
   logic [15:0] v_ctrl;
   logic [15:0] cur;
   logic [15:0] wv;
   logic [4:0]  h12;
   logic        pm;
   logic [7:0]  d_sec;
   logic [7:0]  d_min;
   logic [7:0]  d_hr;
   logic [7:0]  d_date;
   logic [7:0]  d_mon;
   logic [7:0]  d_yr;
   logic [4:0]  w_hour;
   logic        ok_hr;
   logic [5:0]  dim;

   function automatic logic [7:0] enc(input logic bcd, input logic [7:0] v);
      return bcd ? rtcct_to_bcd(v) : v;
   endfunction

   function automatic logic [7:0] dec(input logic bcd, input logic [7:0] v);
      return bcd ? rtcct_from_bcd(v) : v;
   endfunction

   // zero-wait slave: every access completes in its first access cycle
   assign pready  = 1'b1;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;
   assign setup   = psel && !penable;

   always_comb begin
      sel = RTCCT_SEL_NONE;
      case (paddr[ADDR_W-1:2])
         (ADDR_W-2)'(`RTCCT_IDX_SECMIN):  sel = RTCCT_SEL_SECMIN;
         (ADDR_W-2)'(`RTCCT_IDX_HRDAY):   sel = RTCCT_SEL_HRDAY;
         (ADDR_W-2)'(`RTCCT_IDX_DATEMON): sel = RTCCT_SEL_DATEMON;
         (ADDR_W-2)'(`RTCCT_IDX_YEAR):    sel = RTCCT_SEL_YEAR;
         (ADDR_W-2)'(`RTCCT_IDX_CTRL):    sel = RTCCT_SEL_CTRL;
         default:                         sel = RTCCT_SEL_NONE;
      endcase
   end

   // time is kept binary and 24-hour inside; coding and hour mode are views
   always_comb begin
      pm = twelve_r && (t_r.hour >= `RTCCT_HR_NOON);
      if (t_r.hour == 5'h00) begin
         h12 = `RTCCT_HR_NOON;
      end else if (t_r.hour > `RTCCT_HR_NOON) begin
         h12 = t_r.hour - `RTCCT_HR_NOON;
      end else begin
         h12 = t_r.hour;
      end
      v_secmin = '0;
      v_secmin[`RTCCT_MIN_MSB:`RTCCT_MIN_LSB] = 7'(enc(bcd_r, 8'(t_r.min)));
      v_secmin[`RTCCT_SEC_MSB:`RTCCT_SEC_LSB] = 7'(enc(bcd_r, 8'(t_r.sec)));
      v_hrday = '0;
      v_hrday[`RTCCT_WDAY_MSB:`RTCCT_WDAY_LSB] = t_r.wday;
      if (twelve_r) begin
         v_hrday[`RTCCT_PM_BIT] = pm;
         v_hrday[`RTCCT_HR_MSB:`RTCCT_HR_LSB] = 5'(enc(bcd_r, 8'(h12)));
      end else begin
         // 24-hour BCD tens reach bit 5, binary hours leave it zero
         v_hrday[`RTCCT_HR24_MSB:`RTCCT_HR_LSB] = 6'(enc(bcd_r, 8'(t_r.hour)));
      end
      v_datemon = '0;
      v_datemon[`RTCCT_MON_MSB:`RTCCT_MON_LSB]   = 5'(enc(bcd_r, 8'(t_r.month)));
      v_datemon[`RTCCT_DATE_MSB:`RTCCT_DATE_LSB] = 6'(enc(bcd_r, 8'(t_r.date)));
      v_year = '0;
      v_year[`RTCCT_CENT_MSB:`RTCCT_CENT_LSB] = 6'(enc(bcd_r, `RTCCT_CENTURY));
      v_year[`RTCCT_YR_MSB:`RTCCT_YR_LSB]     = enc(bcd_r, t_r.year);
      v_ctrl = '0;
      v_ctrl[`RTCCT_BCD_BIT]  = bcd_r;
      v_ctrl[`RTCCT_12H_BIT]  = twelve_r;
      v_ctrl[`RTCCT_HALT_BIT] = halt_r;
      v_ctrl[`RTCCT_STS_BIT]  = halt_r;
      case (sel)
         RTCCT_SEL_SECMIN:  cur = v_secmin;
         RTCCT_SEL_HRDAY:   cur = v_hrday;
         RTCCT_SEL_DATEMON: cur = v_datemon;
         RTCCT_SEL_YEAR:    cur = v_year;
         RTCCT_SEL_CTRL:    cur = v_ctrl;
         default:           cur = 16'h0000;
      endcase
   end

   // partial byte writes merge with the current coded view
   always_comb begin
      wv[15:8] = pstrb[1] ? pwdata[15:8] : cur[15:8];
      wv[7:0]  = pstrb[0] ? pwdata[7:0] : cur[7:0];
      wr = psel && penable && pwrite && (pstrb[1:0] != 2'b00) && (sel != RTCCT_SEL_NONE);
      d_sec  = dec(bcd_r, 8'(wv[`RTCCT_SEC_MSB:`RTCCT_SEC_LSB]));
      d_min  = dec(bcd_r, 8'(wv[`RTCCT_MIN_MSB:`RTCCT_MIN_LSB]));
      d_date = dec(bcd_r, 8'(wv[`RTCCT_DATE_MSB:`RTCCT_DATE_LSB]));
      d_mon  = dec(bcd_r, 8'(wv[`RTCCT_MON_MSB:`RTCCT_MON_LSB]));
      d_yr   = dec(bcd_r, wv[`RTCCT_YR_MSB:`RTCCT_YR_LSB]);
      if (twelve_r) begin
         d_hr  = dec(bcd_r, 8'(wv[`RTCCT_HR_MSB:`RTCCT_HR_LSB]));
         ok_hr = (d_hr != 8'h00) && (d_hr <= 8'(`RTCCT_HR_NOON));
         w_hour = (d_hr == 8'(`RTCCT_HR_NOON)) ? 5'h00 : d_hr[4:0];
         if (wv[`RTCCT_PM_BIT]) begin
            w_hour = w_hour + `RTCCT_HR_NOON;
         end
      end else begin
         d_hr   = dec(bcd_r, 8'(wv[`RTCCT_HR24_MSB:`RTCCT_HR_LSB]));
         ok_hr  = d_hr <= 8'(`RTCCT_HR_MAX);
         w_hour = d_hr[4:0];
      end
   end

   always_comb begin
      case (t_r.month)
         5'h02:   dim = (t_r.year[1:0] == 2'b00) ? 6'h1D : 6'h1C;
         5'h04:   dim = 6'h1E;
         5'h06:   dim = 6'h1E;
         5'h09:   dim = 6'h1E;
         5'h0B:   dim = 6'h1E;
         default: dim = `RTCCT_DATE_MAX;
      endcase
   end

   assign tick = !halt_r && (pre_r == TICK_LAST);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= 32'h0000_0000;
      end else if (halt_r || tick) begin
         pre_r <= 32'h0000_0000;
      end else begin
         pre_r <= pre_r + 32'h0000_0001;
      end
   end

   // a register write wins over the same cycle's tick for its own fields
   always_comb begin
      t_nxt = t_r;
      if (tick) begin
         if (t_r.sec >= `RTCCT_SEC_MAX) begin
            t_nxt.sec = 7'h00;
            if (t_r.min >= `RTCCT_SEC_MAX) begin
               t_nxt.min = 7'h00;
               if (t_r.hour >= `RTCCT_HR_MAX) begin
                  t_nxt.hour = 5'h00;
                  t_nxt.wday = (t_r.wday >= `RTCCT_WDAY_MAX) ? `RTCCT_RST_WDAY : t_r.wday + 3'h1;
                  if (t_r.date >= dim) begin
                     t_nxt.date = `RTCCT_RST_DATE;
                     if (t_r.month >= `RTCCT_MON_MAX) begin
                        t_nxt.month = `RTCCT_RST_MONTH;
                        t_nxt.year  = (t_r.year >= `RTCCT_YR_MAX) ? 8'h00 : t_r.year + 8'h01;
                     end else begin
                        t_nxt.month = t_r.month + 5'h01;
                     end
                  end else begin
                     t_nxt.date = t_r.date + 6'h01;
                  end
               end else begin
                  t_nxt.hour = t_r.hour + 5'h01;
               end
            end else begin
               t_nxt.min = t_r.min + 7'h01;
            end
         end else begin
            t_nxt.sec = t_r.sec + 7'h01;
         end
      end
      // out-of-range writes are dropped for the whole register
      if (wr) begin
         case (sel)
            RTCCT_SEL_SECMIN: begin
               if (d_sec <= 8'(`RTCCT_SEC_MAX) && d_min <= 8'(`RTCCT_SEC_MAX)) begin
                  t_nxt.sec = d_sec[6:0];
                  t_nxt.min = d_min[6:0];
               end
            end
            RTCCT_SEL_HRDAY: begin
               if (ok_hr && wv[`RTCCT_WDAY_MSB:`RTCCT_WDAY_LSB] != 3'h0) begin
                  t_nxt.hour = w_hour;
                  t_nxt.wday = wv[`RTCCT_WDAY_MSB:`RTCCT_WDAY_LSB];
               end
            end
            RTCCT_SEL_DATEMON: begin
               if (d_date != 8'h00 && d_date <= 8'(`RTCCT_DATE_MAX) && d_mon != 8'h00 &&
                   d_mon <= 8'(`RTCCT_MON_MAX)) begin
                  t_nxt.date  = d_date[5:0];
                  t_nxt.month = d_mon[4:0];
               end
            end
            RTCCT_SEL_YEAR: begin
               if (d_yr <= `RTCCT_YR_MAX) begin
                  t_nxt.year = d_yr;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_r.sec   <= `RTCCT_RST_SEC;
         t_r.min   <= `RTCCT_RST_MIN;
         t_r.hour  <= `RTCCT_RST_HOUR;
         t_r.wday  <= `RTCCT_RST_WDAY;
         t_r.date  <= `RTCCT_RST_DATE;
         t_r.month <= `RTCCT_RST_MONTH;
         t_r.year  <= `RTCCT_RST_YEAR;
      end else begin
         t_r <= t_nxt;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bcd_r    <= 1'b0;
         twelve_r <= 1'b0;
         halt_r   <= 1'b0;
      end else if (wr && sel == RTCCT_SEL_CTRL) begin
         bcd_r    <= wv[`RTCCT_BCD_BIT];
         twelve_r <= wv[`RTCCT_12H_BIT];
         halt_r   <= wv[`RTCCT_HALT_BIT];
      end
   end

   // read data is captured in the setup cycle so it is a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= pwrite ? 32'h0000_0000 : {16'h0000, cur};
         pslverr_r <= (sel == RTCCT_SEL_NONE);
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_sec_step;
      tick && !wr |=> t_r.sec == (($past(t_r.sec) == `RTCCT_SEC_MAX) ? 7'h00 : $past(t_r.sec) + 7'h01);
   endproperty
   a_sec_step: assert property (p_sec_step) else $error("seconds did not step");

   property p_min_carry;
      tick && !wr && t_r.sec == `RTCCT_SEC_MAX && t_r.min != `RTCCT_SEC_MAX |=> t_r.min == $past(t_r.min) + 7'h01;
   endproperty
   a_min_carry: assert property (p_min_carry) else $error("minute carry wrong");

   property p_day_roll;
      tick && !wr && t_r.hour == `RTCCT_HR_MAX && t_r.min == `RTCCT_SEC_MAX && t_r.sec == `RTCCT_SEC_MAX
      |=> t_r.hour == 5'h00 && t_r.wday == (($past(t_r.wday) == 3'h7) ? 3'h1 : $past(t_r.wday) + 3'h1);
   endproperty
   a_day_roll: assert property (p_day_roll) else $error("day rollover wrong");

   property p_ranges;
      t_r.wday != 3'h0 && t_r.hour <= `RTCCT_HR_MAX && t_r.date != 6'h00 && t_r.month != 5'h00 &&
      t_r.month <= `RTCCT_MON_MAX && t_r.year <= `RTCCT_YR_MAX;
   endproperty
   a_ranges: assert property (p_ranges) else $error("calendar field out of range");

   property p_pm_24h;
      setup && !pwrite && sel == RTCCT_SEL_HRDAY && !twelve_r && !bcd_r |=> prdata[`RTCCT_PM_BIT] == 1'b0;
   endproperty
   a_pm_24h: assert property (p_pm_24h) else $error("pm flag set in 24-hour mode");

   property p_pm_12h;
      setup && !pwrite && sel == RTCCT_SEL_HRDAY && twelve_r |=>
      prdata[`RTCCT_PM_BIT] == ($past(t_r.hour) >= `RTCCT_HR_NOON) && prdata[4:0] != 5'h00;
   endproperty
   a_pm_12h: assert property (p_pm_12h) else $error("12-hour read wrong");

   property p_century;
      setup && !pwrite && sel == RTCCT_SEL_YEAR && !bcd_r |=> prdata[13:8] == 6'h14;
   endproperty
   a_century: assert property (p_century) else $error("century not twenty");

   property p_bcd_digit;
      setup && !pwrite && sel == RTCCT_SEL_SECMIN && bcd_r |=> prdata[3:0] <= 4'h9 && prdata[11:8] <= 4'h9;
   endproperty
   a_bcd_digit: assert property (p_bcd_digit) else $error("bcd digit above nine");

   property p_halt_hold;
      halt_r && !wr |=> $stable(t_r) && pre_r == 32'h0000_0000;
   endproperty
   a_halt_hold: assert property (p_halt_hold) else $error("time moved while halted");

   property p_year_wrap;
      tick && !wr && t_r.year == `RTCCT_YR_MAX && t_r.month == `RTCCT_MON_MAX && t_r.date == 6'h1F &&
      t_r.hour == `RTCCT_HR_MAX && t_r.min == `RTCCT_SEC_MAX && t_r.sec == `RTCCT_SEC_MAX
      |=> t_r.year == 8'h00 && t_r.month == 5'h01 && t_r.date == 6'h01;
   endproperty
   a_year_wrap: assert property (p_year_wrap) else $error("year wrap wrong");

   c_min_roll: cover property (tick && t_r.sec == `RTCCT_SEC_MAX);
   c_day_roll: cover property (tick && t_r.hour == `RTCCT_HR_MAX && t_r.min == `RTCCT_SEC_MAX &&
                               t_r.sec == `RTCCT_SEC_MAX);
   c_halted:   cover property ($rose(halt_r));
   c_bcd_rd:   cover property (setup && !pwrite && bcd_r && twelve_r);

endmodule

//--- rtcct_time_regs_test.sv
`timescale 1ns/1ps
`include "rtcct_consts.svh"
`define RTCCT_CHK(what, a, exp, got) begin n_tests++; if ((exp) !== (got)) begin n_mismatch++; \
   $display("[FAIL] %s at %h expected %h seen %h", what, a, exp, got); end end
module rtcct_time_regs_test
   import rtcct_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic        err;
      logic [31:0] data;
      logic [11:0] addr;
   } rtcct_exp_s;

   localparam int unsigned TICK = 40;
   localparam logic [11:0] A_SM  = {`RTCCT_IDX_SECMIN, 2'b00};
   localparam logic [11:0] A_HD  = {`RTCCT_IDX_HRDAY, 2'b00};
   localparam logic [11:0] A_DM  = {`RTCCT_IDX_DATEMON, 2'b00};
   localparam logic [11:0] A_YR  = {`RTCCT_IDX_YEAR, 2'b00};
   localparam logic [11:0] A_CT  = {`RTCCT_IDX_CTRL, 2'b00};
   localparam logic [11:0] A_BAD = 12'h3FC;
   // carry cases from 23:59:59: year end, leap feb, plain feb, 30-day month
   localparam logic [15:0] C_HD [4] = '{16'h0717, 16'h0217, 16'h0217, 16'h0317};
   localparam logic [15:0] C_DM [4] = '{16'h0C1F, 16'h021C, 16'h021C, 16'h041E};
   localparam logic [15:0] C_YR [4] = '{16'h0063, 16'h0004, 16'h0005, 16'h0007};
   localparam logic [15:0] X_HD [4] = '{16'h0100, 16'h0300, 16'h0300, 16'h0400};
   localparam logic [15:0] X_DM [4] = '{16'h0101, 16'h021D, 16'h0301, 16'h0501};
   localparam logic [15:0] X_YR [4] = '{16'h1400, 16'h1404, 16'h1405, 16'h1407};
   // coding views of Thu 23:59:45, year 7
   localparam logic [15:0] M_CT [4] = '{16'h0800, 16'hC800, 16'h4800, 16'h8800};
   localparam logic [15:0] M_HD [4] = '{16'h0517, 16'h0531, 16'h052B, 16'h0523};
   localparam logic [15:0] M_SM [4] = '{16'h3B2D, 16'h5945, 16'h3B2D, 16'h5945};
   localparam logic [15:0] M_YR [4] = '{16'h1407, 16'h2007, 16'h1407, 16'h2007};

   logic        pclk;
   logic        presetn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          n_mismatch;
   int          n_tests;
   rtcct_exp_s  exp_q[$];
   rtcct_exp_s  mon_e;
   logic [6:0]  rs;
   logic [6:0]  rm;
   logic [15:0] last_sm;

   rtcct_time_regs #(.TICK_CYCLES(TICK), .ADDR_W(12)) rtcct_time_regs_inst (
      .pclk    (pclk),
      .presetn (presetn),
      .paddr   (paddr),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   initial pclk = 1'b0;
   always #2.5 pclk = ~pclk;

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // idle edge after each transfer so psel is never assigned twice in one step
   task automatic xfer(input logic [11:0] a, input logic w, input logic [15:0] d, input logic [3:0] s,
                       input logic [15:0] ex, input logic er = 1'b0);
      exp_q.push_back('{wr: w, err: er, data: {16'h0000, ex}, addr: a});
      paddr <= a;
      pwrite <= w;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      psel <= 1'b1;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait that never sees pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      xfer(a, 1'b1, d, 4'h3, 16'h0000);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] ex);
      xfer(a, 1'b0, 16'h0000, 4'h0, ex);
   endtask

   always @(posedge pclk) begin
      // zero-wait slave: every access cycle must show pready
      if (presetn && psel && penable) begin
         `RTCCT_CHK("pready", paddr, 1'b1, pready)
      end
      if (presetn && psel && penable && pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("[FAIL] transfer at %h with no expectation", paddr);
         end else begin
            mon_e = exp_q.pop_front();
            `RTCCT_CHK("pslverr", mon_e.addr, mon_e.err, pslverr)
            if (!mon_e.wr) `RTCCT_CHK("prdata", mon_e.addr, mon_e.data, prdata)
         end
      end
   end

   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      complete_run();
   end

   initial begin
      void'($urandom(32'h412b));
      presetn = 1'b0;
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h0000_0000;
      pstrb = 4'h0;
      n_mismatch = 0;
      n_tests = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset view must be read before the first tick lands
      rd(A_SM, 16'h0000);
      rd(A_HD, 16'h0100);
      rd(A_DM, 16'h0101);
      rd(A_YR, 16'h1400);
      rd(A_CT, 16'h0000);
      repeat (TICK) @(posedge pclk);
      rd(A_SM, 16'h0001);
      wr(A_CT, 16'h0800);
      rd(A_CT, 16'h0C00);
      xfer(12'h050, 1'b0, 16'h0000, 4'h0, 16'h0000, 1'b1);
      xfer(A_BAD, 1'b0, 16'h0000, 4'h3, 16'h0000, 1'b1);
      xfer(A_BAD, 1'b1, 16'h1234, 4'h3, 16'h0000, 1'b1);
      wr(A_SM, 16'h1E0F);
      wr(A_SM, 16'h3C00);
      rd(A_SM, 16'h1E0F);
      wr(A_SM, 16'h003C);
      rd(A_SM, 16'h1E0F);
      xfer(A_SM, 1'b1, 16'h0000, 4'h0, 16'h0000);
      xfer(A_SM, 1'b1, 16'h0005, 4'h1, 16'h0000);
      rd(A_SM, 16'h1E05);
      for (int i = 0; i < 4; i++) begin
         rs = 7'($urandom % 60);
         rm = 7'($urandom % 60);
         last_sm = {1'b0, rm, 1'b0, rs};
         wr(A_SM, last_sm);
         rd(A_SM, last_sm);
      end
      wr(A_HD, 16'h0005);
      wr(A_HD, 16'h0118);
      rd(A_HD, 16'h0100);
      wr(A_DM, 16'h0D01);
      wr(A_DM, 16'h0100);
      rd(A_DM, 16'h0101);
      wr(A_YR, 16'h0064);
      wr(A_YR, 16'h3F05);
      rd(A_YR, 16'h1405);
      repeat (3 * TICK) @(posedge pclk);
      rd(A_SM, last_sm);
      for (int i = 0; i < 4; i++) begin
         wr(A_SM, 16'h3B3B);
         wr(A_HD, C_HD[i]);
         wr(A_DM, C_DM[i]);
         wr(A_YR, C_YR[i]);
         wr(A_CT, 16'h0000);
         // one step lands at TICK, the next would need 2*TICK
         repeat (TICK + 10) @(posedge pclk);
         wr(A_CT, 16'h0800);
         rd(A_SM, 16'h0000);
         rd(A_HD, X_HD[i]);
         rd(A_DM, X_DM[i]);
         rd(A_YR, X_YR[i]);
      end
      // minute carry without an hour carry
      wr(A_SM, 16'h0A3B);
      wr(A_CT, 16'h0000);
      repeat (TICK + 10) @(posedge pclk);
      wr(A_CT, 16'h0800);
      rd(A_SM, 16'h0B00);
      wr(A_SM, 16'h3B2D);
      wr(A_HD, 16'h0517);
      for (int i = 0; i < 4; i++) begin
         wr(A_CT, M_CT[i]);
         rd(A_HD, M_HD[i]);
         rd(A_SM, M_SM[i]);
         rd(A_YR, M_YR[i]);
      end
      // coded writes: 59:30 lands, a bad units digit drops the word
      wr(A_SM, 16'h5930);
      wr(A_SM, 16'h5A00);
      wr(A_CT, 16'h0800);
      rd(A_SM, 16'h3B1E);
      wr(A_CT, 16'h0800);
      wr(A_HD, 16'h0100);
      wr(A_CT, 16'h4800);
      rd(A_HD, 16'h010C);
      wr(A_HD, 16'h022C);
      wr(A_CT, 16'h0800);
      rd(A_HD, 16'h020C);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_HD, 16'h0100);
      rd(A_CT, 16'h0000);
      complete_run();
   end
endmodule
